// ==== include/tel_consts.svh ====
// register offsets, field positions and bus codes of the test error loop block
`ifndef TEL_CONSTS_SVH
`define TEL_CONSTS_SVH

// register map, byte addresses on the AXI4-Lite slave
`define TEL_ADDR_W 8
`define TEL_CTRL_OFS 8'h00
`define TEL_STATUS_OFS 8'h04

// control register fields
`define TEL_CTRL_START_BIT 0

// status register fields
`define TEL_ST_STATE_LSB 0
`define TEL_ST_STATE_MSB 2
`define TEL_ST_MSG_LSB 4
`define TEL_ST_MSG_MSB 7
`define TEL_ST_RESID_BIT 8
`define TEL_ST_RVALID_BIT 9
`define TEL_ST_FAIL_BIT 10
`define TEL_ST_SPEC_BIT 11
`define TEL_ST_MARKER_BIT 12
`define TEL_ST_RERUN_BIT 13

// response codes and reset values
`define TEL_RESP_OKAY 2'b00
`define TEL_RESP_DECERR 2'b11
`define TEL_DATA_ZERO 32'h0000_0000
`define TEL_NUM_KEYS 7

`endif

// ==== include/tel_pkg.sv ====
// types shared by the test error loop block
package tel_pkg;

  // controller states
  typedef enum logic [2:0] {
    TEL_QUIET    = 3'b000,
    TEL_RUN      = 3'b001,
    TEL_STOP_RW  = 3'b010,
    TEL_LOOP_RW  = 3'b011,
    TEL_STOP_CTL = 3'b100,
    TEL_LOOP_CTL = 3'b101
  } tel_state_e;

  // display message codes
  typedef enum logic [3:0] {
    MSG_IDLE         = 4'h0,
    MSG_RUN          = 4'h1,
    MSG_RW_ASK       = 4'h2,
    MSG_RW_ON        = 4'h3,
    MSG_RW_OFF       = 4'h4,
    MSG_RW_STOP_ON   = 4'h5,
    MSG_RW_STOP_OFF  = 4'h6,
    MSG_CTL_ASK      = 4'h7,
    MSG_CTL_ON       = 4'h8,
    MSG_CTL_OFF      = 4'h9,
    MSG_CTL_STOP_ON  = 4'ha,
    MSG_CTL_STOP_OFF = 4'hb,
    MSG_FAIL         = 4'hc,
    MSG_PASS         = 4'hd
  } tel_msg_e;

  // one key command per cycle
  typedef enum logic [2:0] {
    KEY_NONE   = 3'b000,
    KEY_REPEAT = 3'b001,
    KEY_STOP   = 3'b010,
    KEY_LOOP   = 3'b011,
    KEY_YES    = 3'b100,
    KEY_CONT   = 3'b101,
    KEY_NO     = 3'b110,
    KEY_MORE   = 3'b111
  } tel_key_e;

endpackage

// ==== include/tel_core_if.sv ====
// carrier between the controller core, its register slave and key decoder
`timescale 1ns/1ps
interface tel_core_if;
  logic start_p;
  logic [31:0] status;
  tel_pkg::tel_key_e key_cmd;

  modport regs (output start_p, input status);
  modport keys (output key_cmd);
  modport core (input start_p, input key_cmd, output status);
endinterface

// ==== rtl/tel_keys.sv ====
// key decoder: one command per press, fixed priority among keys
`timescale 1ns/1ps
`include "tel_consts.svh"
module tel_keys (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TEL_NUM_KEYS-1:0] keys,
  tel_core_if.keys kif
);
  // bit order of keys: repeat, stop, loop, yes, cont, no, more
  logic [`TEL_NUM_KEYS-1:0] prev_ff;
  logic [`TEL_NUM_KEYS-1:0] rise;
  tel_pkg::tel_key_e nxt_cmd;
  tel_pkg::tel_key_e cmd_ff;

  // a held key counts once; only its rising edge is a press
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= keys;
    end
  end

  assign rise = keys & ~prev_ff;

  // repeat wins, so a restart is never masked by another key
  always_comb begin
    nxt_cmd = tel_pkg::KEY_NONE;
    if (rise[0]) nxt_cmd = tel_pkg::KEY_REPEAT;
    else if (rise[1]) nxt_cmd = tel_pkg::KEY_STOP;
    else if (rise[2]) nxt_cmd = tel_pkg::KEY_LOOP;
    else if (rise[3]) nxt_cmd = tel_pkg::KEY_YES;
    else if (rise[4]) nxt_cmd = tel_pkg::KEY_CONT;
    else if (rise[5]) nxt_cmd = tel_pkg::KEY_NO;
    else if (rise[6]) nxt_cmd = tel_pkg::KEY_MORE;
  end

  // command lives one cycle, so at most one transition per press
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ff <= tel_pkg::KEY_NONE;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  assign kif.key_cmd = cmd_ff;
endmodule // tel_keys

// ==== rtl/tel_axil.sv ====
// axi4-lite slave: control and status registers of the controller
`timescale 1ns/1ps
`include "tel_consts.svh"
module tel_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TEL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TEL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  tel_core_if.regs rif
);
  logic aw_have_ff;
  logic w_have_ff;
  logic [`TEL_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic start_ff;
  logic do_write;

  assign s_axi_awready = !aw_have_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_have_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

  // address and data are latched independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= `TEL_DATA_ZERO;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer decerr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TEL_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_ff == `TEL_CTRL_OFS) ? `TEL_RESP_OKAY :
                     (awaddr_ff == `TEL_STATUS_OFS) ? `TEL_RESP_OKAY :
                     `TEL_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // start is a one-cycle pulse from a write of one to the start bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= do_write && (awaddr_ff == `TEL_CTRL_OFS) &&
                  wstrb_ff[0] && wdata_ff[`TEL_CTRL_START_BIT];
    end
  end

  assign rif.start_p = start_ff;

  // read path; the control register reads as zero, start self-clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `TEL_DATA_ZERO;
      s_axi_rresp <= `TEL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `TEL_STATUS_OFS) begin
        s_axi_rdata <= rif.status;
        s_axi_rresp <= `TEL_RESP_OKAY;
      end else if (s_axi_araddr == `TEL_CTRL_OFS) begin
        s_axi_rdata <= `TEL_DATA_ZERO;
        s_axi_rresp <= `TEL_RESP_OKAY;
      end else begin
        s_axi_rdata <= `TEL_DATA_ZERO;
        s_axi_rresp <= `TEL_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // tel_axil

// ==== rtl/tel_top.sv ====
// test error loop controller: stop, loop, continue and repeat handling
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tel_consts.svh"
module tel_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TEL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TEL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic repeat_key,
  input wire logic stop_key,
  input wire logic loop_key,
  input wire logic yes_key,
  input wire logic cont_key,
  input wire logic no_key,
  input wire logic more_key,
  input wire logic rw_error_det,
  input wire logic control_line_error_det,
  input wire logic error_present,
  input wire logic test_done,
  output logic test_run_ff,
  output logic test_restart_ff,
  output logic loop_op_ff,
  output logic loop_on_ctl_ff,
  output tel_pkg::tel_msg_e msg_ff,
  output logic stopped_lamp_ff,
  output logic looping_lamp_ff,
  output logic more_lamp_ff,
  output logic line2_show_ff,
  output logic err_marker_ff,
  output logic wait_ind_ff,
  output logic beep_ff,
  output logic result_valid_ff,
  output logic result_fail_ff
);
  tel_core_if cif ();

  tel_pkg::tel_state_e state_ff;
  tel_pkg::tel_state_e nxt_state;
  tel_pkg::tel_msg_e nxt_msg;
  tel_pkg::tel_key_e key;
  logic resid_ff;
  logic nxt_resid;
  logic specified_ff;
  logic nxt_specified;
  logic rerun_ff;
  logic nxt_rerun;
  logic nxt_marker;
  logic nxt_line2;
  logic nxt_result_valid;
  logic nxt_result_fail;
  logic restart;
  logic rw_on;
  logic ask;
  logic stop_on;
  logic looping_now;
  logic looping_nxt;

  // register slave: start strobe in, status word out
  tel_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(cif.regs)
  );

  // key decoder: presses become single-cycle commands
  tel_keys u_keys (
    .aclk(aclk),
    .aresetn(aresetn),
    .keys({more_key, no_key, cont_key, yes_key, loop_key, stop_key,
           repeat_key}),
    .kif(cif.keys)
  );

  assign key = cif.key_cmd;

  // a returned control-line error keeps the read/write loop showing error
  assign rw_on = error_present | err_marker_ff;
  assign ask = (msg_ff == tel_pkg::MSG_RW_ASK) ||
               (msg_ff == tel_pkg::MSG_CTL_ASK);
  assign stop_on = (msg_ff != tel_pkg::MSG_RW_STOP_OFF) &&
                   (msg_ff != tel_pkg::MSG_CTL_STOP_OFF);

  // next state, message and flags
  always_comb begin
    nxt_state = state_ff;
    nxt_msg = msg_ff;
    nxt_resid = resid_ff;
    nxt_specified = specified_ff;
    nxt_rerun = rerun_ff;
    nxt_marker = err_marker_ff;
    nxt_line2 = line2_show_ff;
    nxt_result_valid = result_valid_ff;
    nxt_result_fail = result_fail_ff;
    restart = 1'b0;
    if (cif.start_p ||
        (key == tel_pkg::KEY_REPEAT && specified_ff)) begin
      restart = 1'b1;
      nxt_rerun = 1'b0;
      nxt_specified = 1'b1;
    end else begin
      unique case (state_ff)
        tel_pkg::TEL_QUIET: begin
          // loop reruns forever; repeat is caught above and runs once
          if (key == tel_pkg::KEY_LOOP && specified_ff) begin
            restart = 1'b1;
            nxt_rerun = 1'b1;
          end
        end
        tel_pkg::TEL_RUN: begin
          // control-line error ranks above read/write when both arrive
          if (control_line_error_det) begin
            nxt_state = tel_pkg::TEL_STOP_CTL;
            nxt_msg = tel_pkg::MSG_CTL_ASK;
          end else if (rw_error_det) begin
            nxt_state = tel_pkg::TEL_STOP_RW;
            nxt_msg = tel_pkg::MSG_RW_ASK;
          end else if (test_done) begin
            nxt_result_valid = 1'b1;
            nxt_result_fail = resid_ff;
            if (rerun_ff) begin
              restart = 1'b1;
            end else begin
              nxt_state = tel_pkg::TEL_QUIET;
              nxt_msg = resid_ff ? tel_pkg::MSG_FAIL :
                        tel_pkg::MSG_PASS;
            end
          end
        end
        tel_pkg::TEL_STOP_RW: begin
          // yes and no only answer the loop prompt itself
          if (key == tel_pkg::KEY_LOOP ||
              (key == tel_pkg::KEY_YES && ask)) begin
            nxt_state = tel_pkg::TEL_LOOP_RW;
            nxt_msg = (ask || stop_on) ? tel_pkg::MSG_RW_ON :
                      tel_pkg::MSG_RW_OFF;
          end else if (key == tel_pkg::KEY_CONT ||
                       (key == tel_pkg::KEY_NO && ask)) begin
            nxt_state = tel_pkg::TEL_RUN;
            nxt_msg = tel_pkg::MSG_RUN;
            if (stop_on) begin
              nxt_resid = 1'b1;
            end
          end
        end
        tel_pkg::TEL_LOOP_RW: begin
          if (control_line_error_det) begin
            nxt_state = tel_pkg::TEL_STOP_CTL;
            nxt_msg = tel_pkg::MSG_CTL_ASK;
          end else if (key == tel_pkg::KEY_STOP) begin
            nxt_state = tel_pkg::TEL_STOP_RW;
            nxt_msg = rw_on ? tel_pkg::MSG_RW_STOP_ON :
                      tel_pkg::MSG_RW_STOP_OFF;
          end else begin
            nxt_msg = rw_on ? tel_pkg::MSG_RW_ON :
                      tel_pkg::MSG_RW_OFF;
          end
        end
        tel_pkg::TEL_STOP_CTL: begin
          if (key == tel_pkg::KEY_LOOP ||
              (key == tel_pkg::KEY_YES && ask)) begin
            nxt_state = tel_pkg::TEL_LOOP_CTL;
            nxt_msg = (ask || stop_on) ? tel_pkg::MSG_CTL_ON :
                      tel_pkg::MSG_CTL_OFF;
            nxt_line2 = 1'b0;
          end else if (key == tel_pkg::KEY_CONT ||
                       (key == tel_pkg::KEY_NO && ask)) begin
            nxt_state = tel_pkg::TEL_LOOP_RW;
            nxt_msg = tel_pkg::MSG_RW_ON;
            nxt_line2 = 1'b0;
            // only an unremoved control-line error leaves the marker
            if (stop_on) begin
              nxt_marker = 1'b1;
            end
          end else if (key == tel_pkg::KEY_MORE) begin
            nxt_line2 = !line2_show_ff;
          end
        end
        tel_pkg::TEL_LOOP_CTL: begin
          if (key == tel_pkg::KEY_STOP) begin
            nxt_state = tel_pkg::TEL_STOP_CTL;
            nxt_msg = error_present ? tel_pkg::MSG_CTL_STOP_ON :
                      tel_pkg::MSG_CTL_STOP_OFF;
          end else begin
            nxt_msg = error_present ? tel_pkg::MSG_CTL_ON :
                      tel_pkg::MSG_CTL_OFF;
          end
        end
        default: begin
          nxt_state = tel_pkg::TEL_QUIET;
          nxt_msg = tel_pkg::MSG_IDLE;
        end
      endcase
    end
    // every start from the beginning wipes residual errors
    if (restart) begin
      nxt_state = tel_pkg::TEL_RUN;
      nxt_msg = tel_pkg::MSG_RUN;
      nxt_resid = 1'b0;
      nxt_marker = 1'b0;
      nxt_line2 = 1'b0;
    end
  end

  // state and message
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= tel_pkg::TEL_QUIET;
      msg_ff <= tel_pkg::MSG_IDLE;
    end else begin
      state_ff <= nxt_state;
      msg_ff <= nxt_msg;
    end
  end

  // residual errors, marker and test bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resid_ff <= 1'b0;
      err_marker_ff <= 1'b0;
      specified_ff <= 1'b0;
      rerun_ff <= 1'b0;
      line2_show_ff <= 1'b0;
      result_valid_ff <= 1'b0;
      result_fail_ff <= 1'b0;
    end else begin
      resid_ff <= nxt_resid;
      err_marker_ff <= nxt_marker;
      specified_ff <= nxt_specified;
      rerun_ff <= nxt_rerun;
      line2_show_ff <= nxt_line2;
      result_valid_ff <= nxt_result_valid;
      result_fail_ff <= nxt_result_fail;
    end
  end

  assign looping_now = (state_ff == tel_pkg::TEL_LOOP_RW) ||
                       (state_ff == tel_pkg::TEL_LOOP_CTL);
  assign looping_nxt = (nxt_state == tel_pkg::TEL_LOOP_RW) ||
                       (nxt_state == tel_pkg::TEL_LOOP_CTL);

  // beep only on a toggle inside the same loop, not on entering it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beep_ff <= 1'b0;
    end else begin
      beep_ff <= looping_now && (nxt_state == state_ff) &&
                 (nxt_msg != msg_ff);
    end
  end

  // lamps and run and loop controls follow the next state; test_restart_ff follows restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_run_ff <= 1'b0;
      test_restart_ff <= 1'b0;
      loop_op_ff <= 1'b0;
      loop_on_ctl_ff <= 1'b0;
      stopped_lamp_ff <= 1'b0;
      looping_lamp_ff <= 1'b0;
      more_lamp_ff <= 1'b0;
      wait_ind_ff <= 1'b0;
    end else begin
      test_run_ff <= (nxt_state == tel_pkg::TEL_RUN);
      test_restart_ff <= restart;
      loop_op_ff <= looping_nxt;
      loop_on_ctl_ff <= (nxt_state == tel_pkg::TEL_LOOP_CTL);
      stopped_lamp_ff <= (nxt_state == tel_pkg::TEL_STOP_RW) ||
                         (nxt_state == tel_pkg::TEL_STOP_CTL);
      looping_lamp_ff <= looping_nxt;
      more_lamp_ff <= (nxt_state == tel_pkg::TEL_STOP_CTL);
      wait_ind_ff <= (nxt_state == tel_pkg::TEL_RUN) &&
                     !nxt_rerun;
    end
  end

  // status word seen by software
  always_comb begin
    cif.status = `TEL_DATA_ZERO;
    cif.status[`TEL_ST_STATE_MSB:`TEL_ST_STATE_LSB] = state_ff;
    cif.status[`TEL_ST_MSG_MSB:`TEL_ST_MSG_LSB] = msg_ff;
    cif.status[`TEL_ST_RESID_BIT] = resid_ff;
    cif.status[`TEL_ST_RVALID_BIT] = result_valid_ff;
    cif.status[`TEL_ST_FAIL_BIT] = result_fail_ff;
    cif.status[`TEL_ST_SPEC_BIT] = specified_ff;
    cif.status[`TEL_ST_MARKER_BIT] = err_marker_ff;
    cif.status[`TEL_ST_RERUN_BIT] = rerun_ff;
  end
endmodule // tel_top

// ==== sim/tel_props.sv ====
// concurrent checks on the ports of the test error loop controller
`timescale 1ns/1ps
module tel_props (
  input logic aclk,
  input logic aresetn,
  input logic repeat_key,
  input logic stop_key,
  input logic loop_key,
  input logic yes_key,
  input logic cont_key,
  input logic no_key,
  input logic more_key,
  input logic rw_error_det,
  input logic control_line_error_det,
  input logic test_done,
  input logic test_run_ff,
  input logic test_restart_ff,
  input logic loop_op_ff,
  input logic loop_on_ctl_ff,
  input tel_pkg::tel_msg_e msg_ff,
  input logic stopped_lamp_ff,
  input logic looping_lamp_ff,
  input logic more_lamp_ff,
  input logic err_marker_ff,
  input logic wait_ind_ff,
  input logic beep_ff,
  input logic result_valid_ff,
  input logic result_fail_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // one key line only, so key priority cannot hide the press
  wire logic solo = $onehot({repeat_key, stop_key, loop_key, yes_key,
    cont_key, no_key, more_key});
  sequence s_stopped;
    stopped_lamp_ff && !looping_lamp_ff && !test_run_ff;
  endsequence
  sequence s_looping;
    looping_lamp_ff && !stopped_lamp_ff && loop_op_ff;
  endsequence
  // keys show two edges after the sampled rise; restart pulse lasts one cycle
  property p_halt;
    msg_ff == tel_pkg::MSG_RUN && rw_error_det && !control_line_error_det
      |=> s_stopped ##0 msg_ff == tel_pkg::MSG_RW_ASK;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt on error");
  property p_enter;
    $rose(yes_key) && solo && msg_ff == tel_pkg::MSG_RW_ASK |-> ##2 s_looping;
  endproperty
  a_enter: assert property (p_enter) else $error("no loop entry");
  property p_beep;
    looping_lamp_ff && $past(looping_lamp_ff) |-> beep_ff == $changed(msg_ff);
  endproperty
  a_beep: assert property (p_beep) else $error("beep mismatch");
  property p_stop_on;
    $rose(stop_key) && solo && looping_lamp_ff &&
      msg_ff == tel_pkg::MSG_RW_ON
      |-> ##2 s_stopped ##0 msg_ff == tel_pkg::MSG_RW_STOP_ON;
  endproperty
  a_stop_on: assert property (p_stop_on) else $error("bad stop");
  property p_resume;
    $rose(loop_key) && solo && msg_ff == tel_pkg::MSG_RW_STOP_ON
      |-> ##2 s_looping ##0 msg_ff == tel_pkg::MSG_RW_ON;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
  property p_ctl;
    looping_lamp_ff && !loop_on_ctl_ff && control_line_error_det
      |=> s_stopped ##0 msg_ff == tel_pkg::MSG_CTL_ASK && more_lamp_ff;
  endproperty
  a_ctl: assert property (p_ctl) else $error("no preempt");
  property p_back;
    $rose(cont_key) && solo && msg_ff == tel_pkg::MSG_CTL_ASK
      |-> ##2 s_looping ##0 !loop_on_ctl_ff && err_marker_ff &&
      msg_ff == tel_pkg::MSG_RW_ON;
  endproperty
  a_back: assert property (p_back) else $error("bad return");
  property p_ctl_loop;
    $rose(yes_key) && solo && msg_ff == tel_pkg::MSG_CTL_ASK
      |-> ##2 s_looping ##0 loop_on_ctl_ff && msg_ff == tel_pkg::MSG_CTL_ON;
  endproperty
  a_ctl_loop: assert property (p_ctl_loop) else $error("bad ctl loop");
  // a loop-key rerun has no wait lamp and shows no outcome
  property p_done;
    msg_ff == tel_pkg::MSG_RUN && wait_ind_ff && test_done && !rw_error_det
      && !control_line_error_det |=> !test_run_ff && result_valid_ff &&
      msg_ff == (result_fail_ff ? tel_pkg::MSG_FAIL : tel_pkg::MSG_PASS);
  endproperty
  a_done: assert property (p_done) else $error("bad outcome");
  property p_restart;
    $rose(repeat_key) && solo && msg_ff != tel_pkg::MSG_IDLE
      |-> ##2 test_restart_ff && msg_ff == tel_pkg::MSG_RUN;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
endmodule // tel_props

bind tel_top tel_props u_props (.*);

// ==== sim/tel_panel.sv ====
// keypad model: turns a key command into held key lines
`timescale 1ns/1ps
module tel_panel (
  input logic aclk,
  input tel_pkg::tel_key_e cmd,
  output logic [6:0] keys
);
  // key stays down while the command is held, as a finger would
  always_ff @(posedge aclk) begin
    keys <= (cmd == tel_pkg::KEY_NONE) ? 7'h00 : 7'h01 << (cmd - 3'h1);
  end
endmodule // tel_panel

// ==== sim/tel_top_tb.sv ====
// self-checking bench for the test error loop controller
`timescale 1ns/1ps
`include "tel_consts.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tel_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, rw_error_det, control_line_error_det;
  logic error_present, test_done;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic test_run_ff, test_restart_ff, loop_op_ff, loop_on_ctl_ff;
  logic stopped_lamp_ff, looping_lamp_ff, more_lamp_ff, line2_show_ff;
  logic err_marker_ff, wait_ind_ff, beep_ff, result_valid_ff, result_fail_ff;
  tel_pkg::tel_msg_e msg_ff;
  wire logic repeat_key, stop_key, loop_key, yes_key, cont_key, no_key, more_key;
  tel_pkg::tel_key_e cmd;
  int error_cnt, samples_checked, beeps, restarts, cyc;
  // step code: key, error present, {done,ctl,rw} pulse, expected message
  logic [15:0] tbl [0:38] = '{16'h1000, 16'h0012, 16'h4103, 16'h0004,
    16'h0103, 16'h2105, 16'h3103, 16'h0004, 16'h2006, 16'h3004, 16'h2006,
    16'h5001, 16'h0112, 16'h3103, 16'h2105, 16'h5101, 16'h0112, 16'h3103,
    16'h0127, 16'h7107, 16'h5103, 16'h0003, 16'h0027, 16'h4108, 16'h0009,
    16'h200b, 16'h3009, 16'h0108, 16'h210a, 16'h5103, 16'h2105, 16'h5101,
    16'h004c, 16'h1001, 16'h004d, 16'h3001, 16'h0041, 16'h0112, 16'h1001};

  tel_top uut (.*);
  tel_panel u_panel (.aclk(aclk), .cmd(cmd), .keys({more_key, no_key,
    cont_key, yes_key, loop_key, stop_key, repeat_key}));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog and event counters; run needs well under 1000 cycles
  always @(posedge aclk) begin
    cyc++;
    beeps += (beep_ff === 1'b1);
    restarts += (test_restart_ff === 1'b1);
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // response taken at the handshake edge itself
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er,
                     output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    `CHK("rresp", er, s_axi_rresp)
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // key is held three cycles; only its rise may count
  task automatic run(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      error_present <= tbl[i][8];
      repeat (2) @(posedge aclk);
      {test_done, control_line_error_det, rw_error_det} <= tbl[i][6:4];
      @(posedge aclk);
      {test_done, control_line_error_det, rw_error_det} <= 3'h0;
      cmd <= tel_pkg::tel_key_e'(tbl[i][14:12]);
      repeat (3) @(posedge aclk);
      cmd <= tel_pkg::KEY_NONE;
      repeat (5) @(posedge aclk);
      `CHK("msg", tbl[i][3:0], msg_ff)
    end
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 4'h0;
    {s_axi_arvalid, s_axi_rready, rw_error_det} <= 3'h0;
    {control_line_error_det, error_present, test_done} <= 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
    s_axi_wstrb <= 4'hf;
    cmd <= tel_pkg::KEY_NONE;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`TEL_STATUS_OFS, `TEL_RESP_OKAY, rd);
    `CHK("status", 32'h0000_0000, rd)
    axr(8'h08, `TEL_RESP_DECERR, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    axw(8'h08, 32'h0000_0001, `TEL_RESP_DECERR);
    run(0, 0);
    axw(`TEL_CTRL_OFS, 32'h0000_0001, `TEL_RESP_OKAY);
    repeat (3) @(posedge aclk);
    axr(`TEL_STATUS_OFS, `TEL_RESP_OKAY, rd);
    `CHK("started", 32'h0000_0811, rd)
    run(1, 11);
    `CHK("beeps", 3, beeps)
    `CHK("restarts", 1, restarts)
    axr(`TEL_STATUS_OFS, `TEL_RESP_OKAY, rd);
    `CHK("resid", 1'b0, rd[8])
    run(12, 15);
    axr(`TEL_STATUS_OFS, `TEL_RESP_OKAY, rd);
    `CHK("resid", 1'b1, rd[8])
    run(16, 19);
    `CHK("more", 1'b1, more_lamp_ff)
    `CHK("line2", 1'b1, line2_show_ff)
    run(20, 21);
    `CHK("marker", 1'b1, err_marker_ff)
    run(22, 32);
    `CHK("fail", 1'b1, result_fail_ff)
    run(33, 33);
    `CHK("restarts", 2, restarts)
    run(34, 35);
    `CHK("wait", 1'b0, wait_ind_ff)
    run(36, 36);
    `CHK("restarts", 4, restarts)
    run(37, 38);
    `CHK("restarts", 5, restarts)
    give_verdict();
  end
endmodule // tel_top_tb
